/* verilog/sfcfe_top.sv */
// Purpose: Serial flash command front end: opcode, address, dummy, data
// Assumes: Host clock at most a quarter of clk_sys_i per half period
// Notes: Pins pass a three-stage synchroniser; sclk edges are found here
`timescale 1ns/1ps
module sfcfe_top
   import sfcfe_pkg::*;
#(
   parameter int LOCK_DEPTH = 512
) (
   input wire logic clk_sys_i, // System clock, 20 MHz
   input wire logic reset_i, // Async reset, active high
   input wire logic sclk_i, // Serial clock from host
   input wire logic cs_n_i, // Chip select, active low
   input wire logic [3:0] sio_i, // Serial lines in
   output logic [3:0] sio_o, // Serial lines out
   output logic [3:0] sio_oe_o, // Line drive enables
   input wire logic [1:0] dummy_cfg_i, // {dummy_count_high_bit, dummy_count_low_bit}
   input wire logic busy_i, // Write operation in progress
   output logic [23:0] arr_addr_o, // Array byte address
   output logic arr_req_o, // Array read pulse
   input wire logic [7:0] arr_data_i, // Array data, cycle after request
   input wire logic lock_wr_i, // Lock bit write
   input wire logic [23:0] lock_addr_i, // Lock unit address
   input wire logic lock_val_i, // Lock bit value
   output logic addr_locked_o, // Current read unit locked
   output logic [11:0] sector_o, // Current read sector
   output logic [7:0] block64_o, // Current read 64 KB block
   output logic active_o, // Valid command in progress
   output logic quad_mode_o, // four_line_command_mode
   output logic cmd_exec_o, // Write-type command accepted
   output logic [7:0] cmd_opcode_o // Its opcode
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [5:0] pins_s;
   logic [3:0] sio_s;
   logic sclk_s, cs_n_s, sclk_d_ff, cs_n_d_ff, rise, fall, cs_fall, cs_rise;
   sfcfe_pin_sync #(.WIDTH(6), .RESET_VAL(`SFCFE_PIN_RESET)) u_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .pin_i({sio_i, cs_n_i, sclk_i}),
      .pin_o(pins_s)
   );

   assign sclk_s = pins_s[0];
   assign cs_n_s = pins_s[1];
   assign sio_s = pins_s[5:2];

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         sclk_d_ff <= 1'b0;
         cs_n_d_ff <= 1'b1;
      end else begin
         sclk_d_ff <= sclk_s;
         cs_n_d_ff <= cs_n_s;
      end
   end

   // Edges only count inside a frame, so the idle level does not matter
   assign rise = sclk_s & ~sclk_d_ff & ~cs_n_s & ~cs_n_d_ff;
   assign fall = ~sclk_s & sclk_d_ff & ~cs_n_s & ~cs_n_d_ff;
   assign cs_fall = cs_n_d_ff & ~cs_n_s;
   assign cs_rise = ~cs_n_d_ff & cs_n_s;

   ////////////////////////////////////////////////////////////////////////////////
   sfcfe_state_t state_ff;
   sfcfe_dec_t dec_ff, nxt_dec;
   logic [7:0] op_ff, nxt_op;
   logic [23:0] addr_ff, nxt_addr, op_sh;
   logic [4:0] cnt_ff, dummy_ff, nxt_dummy, op_edges, addr_edges;
   logic [2:0] bit_mod_ff, op_w;
   logic quad_ff, sample, addr_last, enter_data, exec_ok;
   always_comb begin
      op_w = quad_ff ? 3'h4 : 3'h1;
      op_edges = quad_ff ? 5'h02 : 5'h08;
      op_sh = sfcfe_shift({16'h0000, op_ff}, sio_s, op_w);
      nxt_op = op_sh[7:0];
      nxt_dec = sfcfe_decode(nxt_op, quad_ff, busy_i);
      nxt_addr = sfcfe_shift(addr_ff, sio_s, dec_ff.addr_w);
      nxt_dummy = sfcfe_dummy(op_ff, dummy_cfg_i);
      case (dec_ff.addr_w)
         3'h1: addr_edges = 5'h18;
         3'h2: addr_edges = 5'h0C;
         default: addr_edges = 5'h06;
      endcase
   end

   // The double-rate read also takes address nibbles on falling edges
   assign sample = rise | (fall & dec_ff.dtr & (state_ff == ST_ADDR));
   assign addr_last = (state_ff == ST_ADDR) && sample && (cnt_ff == addr_edges - 5'h01);
   assign enter_data = (addr_last && (nxt_dummy == 5'h00)) ||
                       ((state_ff == ST_DUMMY) && rise && (dummy_ff == 5'h01));

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= ST_IDLE;
         dec_ff <= '0;
         op_ff <= 8'h00;
         addr_ff <= 24'h00_0000;
         cnt_ff <= 5'h00;
         dummy_ff <= 5'h00;
      end else if (cs_fall) begin
         state_ff <= ST_OPC;
         dec_ff <= '0;
         op_ff <= 8'h00;
         addr_ff <= 24'h00_0000;
         cnt_ff <= 5'h00;
         dummy_ff <= 5'h00;
      end else if (cs_n_s) begin
         state_ff <= ST_IDLE;
      end else if (sample) begin
         unique case (state_ff)
            ST_OPC: begin
               op_ff <= nxt_op;
               cnt_ff <= cnt_ff + 5'h01;
               if (cnt_ff == op_edges - 5'h01) begin
                  dec_ff <= nxt_dec;
                  cnt_ff <= 5'h00;
                  if (!nxt_dec.valid) begin
                     state_ff <= ST_STBY;
                  end else if (nxt_dec.is_read) begin
                     state_ff <= ST_ADDR;
                  end else begin
                     state_ff <= ST_WAIT;
                  end
               end
            end
            ST_ADDR: begin
               addr_ff <= nxt_addr;
               cnt_ff <= cnt_ff + 5'h01;
               if (addr_last) begin
                  dummy_ff <= nxt_dummy;
                  state_ff <= (nxt_dummy == 5'h00) ? ST_DATA : ST_DUMMY;
               end
            end
            ST_DUMMY: begin
               if (rise) begin
                  dummy_ff <= dummy_ff - 5'h01;
                  if (dummy_ff == 5'h01) begin
                     state_ff <= ST_DATA;
                  end
               end
            end
            ST_IDLE, ST_DATA, ST_WAIT, ST_STBY: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Byte-boundary tracking for write-type commands
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         bit_mod_ff <= 3'h0;
      end else if (cs_fall) begin
         bit_mod_ff <= 3'h0;
      end else if (rise && (state_ff == ST_OPC || state_ff == ST_WAIT)) begin
         bit_mod_ff <= bit_mod_ff + op_w;
      end
   end

   assign exec_ok = cs_rise && (state_ff == ST_WAIT) && (bit_mod_ff == 3'h0);

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         cmd_exec_o <= 1'b0;
         cmd_opcode_o <= 8'h00;
      end else begin
         cmd_exec_o <= exec_ok;
         if (exec_ok) begin
            cmd_opcode_o <= op_ff;
         end
      end
   end

   // Quad-enable configuration bit is not touched here
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         quad_ff <= 1'b0;
      end else if (exec_ok && op_ff == `SFCFE_OP_ENTER_QUAD) begin
         quad_ff <= 1'b1;
      end else if (exec_ok && op_ff == `SFCFE_OP_LEAVE_QUAD) begin
         quad_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         active_o <= 1'b0;
      end else begin
         active_o <= !cs_n_s && (state_ff inside {ST_ADDR, ST_DUMMY, ST_DATA, ST_WAIT});
      end
   end

   assign quad_mode_o = quad_ff;

   ////////////////////////////////////////////////////////////////////////////////
   sfcfe_fetch_t fetch_ff;
   logic [7:0] next_ff, sh_ff, src;
   logic [3:0] left_ff, mask;
   logic [2:0] dw;
   logic req_d_ff, started_ff, out_evt;
   assign dw = dec_ff.data_w;
   // First data bit always leaves on a falling edge
   assign out_evt = (state_ff == ST_DATA) && !cs_n_s &&
                    (fall || (rise && dec_ff.dtr && started_ff));
   assign src = (left_ff == 4'h0) ? next_ff : sh_ff;
   assign mask = (dw == 3'h1) ? 4'h2 : ((dw == 3'h2) ? 4'h3 : 4'hF);

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         fetch_ff <= '0;
         req_d_ff <= 1'b0;
         next_ff <= 8'h00;
      end else begin
         fetch_ff.req <= 1'b0;
         req_d_ff <= fetch_ff.req;
         if (req_d_ff) begin
            next_ff <= arr_data_i;
         end
         if (enter_data) begin
            fetch_ff.addr <= (state_ff == ST_ADDR) ? nxt_addr : addr_ff;
            fetch_ff.req <= 1'b1;
         end else if (out_evt && left_ff == 4'h0) begin
            fetch_ff.addr <= fetch_ff.addr + 24'h00_0001;
            fetch_ff.req <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         sh_ff <= 8'h00;
         left_ff <= 4'h0;
         started_ff <= 1'b0;
         sio_o <= 4'h0;
         sio_oe_o <= 4'h0;
      end else if (state_ff != ST_DATA || cs_n_s) begin
         // Release lines at once so a CS rise mid-byte ends cleanly
         left_ff <= 4'h0;
         started_ff <= 1'b0;
         sio_oe_o <= 4'h0;
      end else if (out_evt) begin
         started_ff <= 1'b1;
         sh_ff <= src << dw;
         left_ff <= ((left_ff == 4'h0) ? 4'h8 : left_ff) - {1'b0, dw};
         sio_oe_o <= mask;
         case (dw)
            3'h1: sio_o <= {2'b00, src[7], 1'b0};
            3'h2: sio_o <= {2'b00, src[7:6]};
            default: sio_o <= src[7:4];
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         sector_o <= 12'h000;
         block64_o <= 8'h00;
      end else begin
         sector_o <= fetch_ff.addr[23:`SFCFE_SECTOR_LSB];
         block64_o <= fetch_ff.addr[23:`SFCFE_BLK64_LSB];
      end
   end

   sfcfe_lock_map #(.DEPTH(LOCK_DEPTH)) u_lock (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .wr_en_i(lock_wr_i),
      .wr_addr_i(lock_addr_i),
      .wr_val_i(lock_val_i),
      .rd_addr_i(fetch_ff.addr),
      .locked_o(addr_locked_o)
   );

   assign arr_addr_o = fetch_ff.addr;
   assign arr_req_o = fetch_ff.req;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   a_cs_restart: assert property (cs_fall |=> state_ff == ST_OPC && cnt_ff == 5'h00)
      else $error("decode not restarted on select fall");
   a_unknown_stby: assert property ((state_ff == ST_OPC) && sample && !cs_fall && !cs_n_s &&
      cnt_ff == op_edges - 5'h01 && !nxt_dec.valid |=> state_ff == ST_STBY)
      else $error("unknown opcode did not go to standby");
   a_stby_quiet: assert property (state_ff == ST_STBY |=> sio_oe_o == 4'h0)
      else $error("lines driven in standby");
   a_end_clean: assert property (cs_rise |=> sio_oe_o == 4'h0 ##1 sio_oe_o == 4'h0)
      else $error("lines still driven after select rise");
   a_exec_bound: assert property (cmd_exec_o |-> $past(bit_mod_ff) == 3'h0 &&
      $past(state_ff) == ST_WAIT)
      else $error("command executed off a byte boundary");
   a_quad_enter: assert property (exec_ok && op_ff == `SFCFE_OP_ENTER_QUAD |=>
      quad_mode_o && cmd_exec_o)
      else $error("four-line mode not entered");
   a_quad_leave: assert property (exec_ok && op_ff == `SFCFE_OP_LEAVE_QUAD |=>
      !quad_mode_o)
      else $error("four-line mode not left");
   a_busy_reject: assert property (state_ff == ST_ADDR |-> !$past(busy_i) ||
      $past(state_ff) == ST_ADDR)
      else $error("read accepted while busy");
   a_quad_reads: assert property (state_ff == ST_ADDR && quad_mode_o |->
      op_ff == `SFCFE_OP_QUAD_AD || op_ff == `SFCFE_OP_QUAD_DTR)
      else $error("single-line read accepted in four-line mode");
   a_addr_step: assert property (out_evt && left_ff == 4'h0 && !enter_data |=>
      arr_req_o && arr_addr_o == $past(fetch_ff.addr) + 24'h00_0001)
      else $error("read address did not advance by one");
   a_drive_fall: assert property ($past(state_ff) == ST_DATA && !dec_ff.dtr &&
      $changed(sio_o) |-> $past(fall))
      else $error("output changed off a falling edge");

   c_quad_enter: cover property (exec_ok && op_ff == `SFCFE_OP_ENTER_QUAD);
   c_read_data: cover property (state_ff == ST_DATA && out_evt);
   c_standby: cover property (state_ff == ST_STBY);
   c_dtr_read: cover property (out_evt && dec_ff.dtr && rise);
endmodule

/* include/sfcfe_regs.svh */
// Purpose: Opcodes, dummy counts and address map constants
// Assumes: 24-bit byte address
// Notes: Definitions only
`ifndef SFCFE_REGS_SVH
`define SFCFE_REGS_SVH
`define SFCFE_OP_READ 8'h03
`define SFCFE_OP_FAST 8'h0B
`define SFCFE_OP_DUAL_AD 8'hBB
`define SFCFE_OP_DUAL_OUT 8'h3B
`define SFCFE_OP_QUAD_AD 8'hEB
`define SFCFE_OP_QUAD_OUT 8'h6B
`define SFCFE_OP_QUAD_DTR 8'hED
`define SFCFE_OP_ENTER_QUAD 8'h35
`define SFCFE_OP_LEAVE_QUAD 8'hF5
`define SFCFE_OP_QPG 8'h38
`define SFCFE_OP_WPSEL 8'h68
`define SFCFE_OPS_WRITE 8'h06, 8'h04, 8'h41, 8'h01, 8'h02, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7
`define SFCFE_ADDR_BITS 24
`define SFCFE_DUMMY_FAST 5'h08
`define SFCFE_DUMMY_DUAL_AD 5'h04
`define SFCFE_DUMMY_QUAD_AD 5'h06
`define SFCFE_DUMMY_DC01 5'h06
`define SFCFE_DUMMY_DC10 5'h08
`define SFCFE_DUMMY_DC11 5'h0A
`define SFCFE_SECTOR_LSB 12
`define SFCFE_BLK64_LSB 16
`define SFCFE_LOCK_TOP_BASE 9'h010
`define SFCFE_LOCK_MID_OFS 9'h01F
`define SFCFE_PIN_RESET 6'h02
`endif

/* include/sfcfe_pkg.sv */
// Purpose: Types and shared functions of the command front end
// Assumes: sfcfe_regs.svh on the include path
// Notes: None
package sfcfe_pkg;
`include "sfcfe_regs.svh"

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_OPC = 7'h02,
      ST_ADDR = 7'h04,
      ST_DUMMY = 7'h08,
      ST_DATA = 7'h10,
      ST_WAIT = 7'h20,
      ST_STBY = 7'h40
   } sfcfe_state_t;

   typedef struct packed {
      logic valid;
      logic is_read;
      logic [2:0] addr_w;
      logic [2:0] data_w;
      logic dtr;
   } sfcfe_dec_t;

   typedef struct packed {
      logic [23:0] addr;
      logic req;
   } sfcfe_fetch_t;

   function automatic logic [23:0] sfcfe_shift(input logic [23:0] sr, input logic [3:0] b,
                                               input logic [2:0] w);
      case (w)
         3'h1: return {sr[22:0], b[0]};
         3'h2: return {sr[21:0], b[1:0]};
         default: return {sr[19:0], b};
      endcase
   endfunction

   function automatic sfcfe_dec_t sfcfe_decode(input logic [7:0] op, input logic quad,
                                               input logic busy);
      sfcfe_dec_t d;
      d = '0;
      case (op)
         `SFCFE_OP_READ, `SFCFE_OP_FAST: d = '{!quad, 1'b1, 3'h1, 3'h1, 1'b0};
         `SFCFE_OP_DUAL_AD: d = '{!quad, 1'b1, 3'h2, 3'h2, 1'b0};
         `SFCFE_OP_DUAL_OUT: d = '{!quad, 1'b1, 3'h1, 3'h2, 1'b0};
         `SFCFE_OP_QUAD_OUT: d = '{!quad, 1'b1, 3'h1, 3'h4, 1'b0};
         `SFCFE_OP_QUAD_AD: d = '{1'b1, 1'b1, 3'h4, 3'h4, 1'b0};
         `SFCFE_OP_QUAD_DTR: d = '{1'b1, 1'b1, 3'h4, 3'h4, 1'b1};
         `SFCFE_OP_QPG, `SFCFE_OP_WPSEL: d.valid = !quad;
         `SFCFE_OP_ENTER_QUAD, `SFCFE_OP_LEAVE_QUAD, `SFCFE_OPS_WRITE: d.valid = 1'b1;
         default: d = '0;
      endcase
      // Array reads are dropped while a write operation runs
      if (d.is_read && busy) begin
         d.valid = 1'b0;
      end
      return d;
   endfunction

   function automatic logic [4:0] sfcfe_dummy(input logic [7:0] op, input logic [1:0] dc);
      if (op == `SFCFE_OP_READ) begin
         return 5'h00;
      end
      case (dc)
         2'h1: return `SFCFE_DUMMY_DC01;
         2'h2: return `SFCFE_DUMMY_DC10;
         2'h3: return `SFCFE_DUMMY_DC11;
         default: begin
            if (op == `SFCFE_OP_DUAL_AD) begin
               return `SFCFE_DUMMY_DUAL_AD;
            end
            if (op == `SFCFE_OP_QUAD_AD || op == `SFCFE_OP_QUAD_DTR) begin
               return `SFCFE_DUMMY_QUAD_AD;
            end
            return `SFCFE_DUMMY_FAST;
         end
      endcase
   endfunction
endpackage

/* verilog/sfcfe_pin_sync.sv */
// Purpose: Three-stage synchroniser for pins from outside the clock domain
// Assumes: Each bit may change at any time
// Notes: A change counts once stages two and three agree
`timescale 1ns/1ps
module sfcfe_pin_sync #(
   parameter int WIDTH = 6,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk_sys_i, // System clock
   input wire logic reset_i, // Async reset, active high
   input wire logic [WIDTH-1:0] pin_i, // Raw pins
   output logic [WIDTH-1:0] pin_o // Filtered pins
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] out_ff;

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         s1_ff <= RESET_VAL;
         s2_ff <= RESET_VAL;
         s3_ff <= RESET_VAL;
      end else begin
         s1_ff <= pin_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         out_ff <= RESET_VAL;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               out_ff[i] <= s3_ff[i];
            end
         end
      end
   end

   assign pin_o = out_ff;
endmodule

/* verilog/sfcfe_lock_map.sv */
// Purpose: Lock bit per protection unit, with address to unit mapping
// Assumes: Lock writes come from logic on the same clock
// Notes: End 64 KB regions lock per 4 KB sector, the rest per 64 KB block
`timescale 1ns/1ps
module sfcfe_lock_map
   import sfcfe_pkg::*;
#(
   parameter int DEPTH = 512
) (
   input wire logic clk_sys_i, // System clock
   input wire logic reset_i, // Async reset, active high
   input wire logic wr_en_i, // Write one lock bit
   input wire logic [23:0] wr_addr_i, // Any byte inside the unit
   input wire logic wr_val_i, // New lock value
   input wire logic [23:0] rd_addr_i, // Address to look up
   output logic locked_o // Lock of that unit, registered
);
   logic mem_ff [DEPTH];
   logic rd_ff;

   function automatic logic [8:0] unit_of(input logic [23:0] a);
      logic [7:0] blk;
      logic [3:0] sec;
      blk = a[23:`SFCFE_BLK64_LSB];
      sec = a[15:`SFCFE_SECTOR_LSB];
      if (blk == 8'h00) begin
         return {5'h00, sec};
      end
      if (blk == 8'hFF) begin
         return `SFCFE_LOCK_TOP_BASE + {5'h00, sec};
      end
      return `SFCFE_LOCK_MID_OFS + {1'b0, blk};
   endfunction

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= 1'b0;
         end
      end else if (wr_en_i) begin
         mem_ff[unit_of(wr_addr_i)] <= wr_val_i;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         rd_ff <= 1'b0;
      end else begin
         rd_ff <= mem_ff[unit_of(rd_addr_i)];
      end
   end

   assign locked_o = rd_ff;
endmodule

/* tb/sfcfe_host_model.sv */
// Purpose: Host controller model driving sclk, chip select and lines
// Assumes: Half period of four system clocks (400 ns sclk)
// Notes: Unused lines show the inverse of their last value
`timescale 1ns/1ps
module sfcfe_host_model (
   input wire logic clk_sys_i, // System clock
   input wire logic [3:0] line_i, // Resolved serial lines
   output logic sclk_o, // Serial clock
   output logic cs_n_o, // Chip select, active low
   output logic [3:0] sio_o // Host line drive
);
   logic idle_hi;
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sio_o = 4'h0;
      idle_hi = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // Idle level picks mode 0 or mode 3
   task automatic open_frame(input logic hi);
      idle_hi = hi;
      sclk_o <= hi;
      wt(4);
      cs_n_o <= 1'b0;
      wt(4);
   endtask
   // Bits change after the fall and are held over the rise
   task automatic send(input logic [7:0] v, input int w, input int nb);
      logic [7:0] sr;
      sr = v;
      for (int i = 0; i < nb; i++) begin
         sclk_o <= 1'b0;
         sio_o <= (w == 4) ? sr[7:4] : {~sio_o[3:1], sr[7]};
         sr = (w == 4) ? {sr[3:0], 4'h0} : {sr[6:0], 1'b0};
         wt(4);
         sclk_o <= 1'b1;
         wt(4);
      end
   endtask
   // Sampled late in the high half, after the device's fall-launched bit settles
   task automatic recv(output logic [7:0] v);
      v = 8'h00;
      for (int i = 0; i < 8; i++) begin
         sclk_o <= 1'b0;
         sio_o <= ~sio_o;
         wt(4);
         sclk_o <= 1'b1;
         wt(3);
         @(negedge clk_sys_i) v = {v[6:0], line_i[1]};
         wt(1);
      end
   endtask
   task automatic close_frame();
      sclk_o <= idle_hi;
      wt(4);
      cs_n_o <= 1'b1;
      sio_o <= ~sio_o;
      wt(8);
   endtask
endmodule

/* tb/sfcfe_top_tb.sv */
// Purpose: Self-checking bench of the command front end
// Assumes: Host model on the serial side, array modelled here
// Notes: Dummy configuration bits zero except in the fast read scenario
`timescale 1ns/1ps
module sfcfe_top_tb;
   import sfcfe_pkg::*;
   logic clk_sys_i, reset_i, sclk, cs_n, busy_i, lock_wr_i, lock_val_i, arr_req_o;
   logic active_o, quad_mode_o, cmd_exec_o, addr_locked_o;
   logic [3:0] host_sio, dut_sio, sio_oe_o, line;
   logic [7:0] arr_data_i, cmd_opcode_o, b0, b1, block64_o;
   logic [11:0] sector_o;
   logic [1:0] dummy_cfg;
   logic [23:0] arr_addr_o, lock_addr_i;
   logic [23:0] addr_q[$];
   int err_count, total_checks, exec_cnt, e0;
   for (genvar k = 0; k < 4; k++) begin : g_line
      assign line[k] = sio_oe_o[k] ? dut_sio[k] : host_sio[k];
   end
   sfcfe_host_model h (.clk_sys_i(clk_sys_i), .line_i(line), .sclk_o(sclk), .cs_n_o(cs_n),
      .sio_o(host_sio));
   sfcfe_top DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .sio_i(line), .sio_o(dut_sio), .sio_oe_o(sio_oe_o), .dummy_cfg_i(dummy_cfg),
      .busy_i(busy_i),
      .arr_addr_o(arr_addr_o), .arr_req_o(arr_req_o), .arr_data_i(arr_data_i),
      .lock_wr_i(lock_wr_i), .lock_addr_i(lock_addr_i), .lock_val_i(lock_val_i),
      .addr_locked_o(addr_locked_o), .sector_o(sector_o), .block64_o(block64_o),
      .active_o(active_o), .quad_mode_o(quad_mode_o), .cmd_exec_o(cmd_exec_o),
      .cmd_opcode_o(cmd_opcode_o));
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // Array returns a pattern of the address one cycle after any request
   always @(posedge clk_sys_i) begin
      arr_data_i <= arr_addr_o[7:0] ^ 8'h5A;
      if (arr_req_o) addr_q.push_back(arr_addr_o);
      if (cmd_exec_o) exec_cnt++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Mode 3 read at the top address, streaming across the wrap
   task automatic t_read();
      lock_addr_i <= 24'hFF_F000;
      lock_val_i <= 1'b1;
      lock_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      lock_wr_i <= 1'b0;
      h.open_frame(1'b1);
      h.send(8'h03, 1, 8);
      for (int i = 0; i < 3; i++) h.send(8'hFF, 1, 8);
      // The next byte is prefetched at the first output fall, so look before it
      repeat (4) @(posedge clk_sys_i);
      chk("sector", sector_o, 12'hFFF);
      chk("block64", block64_o, 8'hFF);
      chk("locked_top", addr_locked_o, 1);
      h.recv(b0);
      chk("active", active_o, 1);
      h.recv(b1);
      chk("locked_zero", addr_locked_o, 0);
      chk("sector_zero", sector_o, 12'h000);
      h.close_frame();
      chk("byte0", b0, 8'hA5);
      chk("byte1", b1, 8'h5A);
      chk("req_count", addr_q.size(), 3);
      chk("addr0", addr_q[0], 24'hFF_FFFF);
      chk("addr1", addr_q[1], 24'h00_0000);
      chk("addr2", addr_q[2], 24'h00_0001);
      chk("oe_off", sio_oe_o, 4'h0);
   endtask
   // Fast read with a configured dummy count, inside a locked middle block
   task automatic t_fast();
      dummy_cfg <= 2'h1;
      lock_addr_i <= 24'h12_0000;
      lock_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      lock_wr_i <= 1'b0;
      h.open_frame(1'b0);
      h.send(8'h0B, 1, 8);
      h.send(8'h12, 1, 8);
      h.send(8'h34, 1, 8);
      h.send(8'h56, 1, 8);
      h.send(8'h00, 1, 6);
      h.recv(b0);
      chk("fast_sector", sector_o, 12'h123);
      chk("fast_block", block64_o, 8'h12);
      chk("locked_mid", addr_locked_o, 1);
      h.close_frame();
      chk("fast_byte", b0, 8'h0C);
      dummy_cfg <= 2'h0;
   endtask
   // Unknown opcode, then write-type on and off a byte boundary
   task automatic t_cmd();
      h.open_frame(1'b0);
      h.send(8'h9F, 1, 8);
      chk("stby_active", active_o, 0);
      h.send(8'h35, 1, 8);
      chk("stby_oe", sio_oe_o, 4'h0);
      h.close_frame();
      chk("stby_quad", quad_mode_o, 0);
      e0 = exec_cnt;
      h.open_frame(1'b0);
      h.send(8'h06, 1, 8);
      h.close_frame();
      chk("exec_on", exec_cnt - e0, 1);
      chk("exec_op", cmd_opcode_o, 8'h06);
      h.open_frame(1'b0);
      h.send(8'h04, 1, 8);
      h.send(8'h00, 1, 3);
      h.close_frame();
      chk("exec_off", exec_cnt - e0, 1);
      chk("exec_op_held", cmd_opcode_o, 8'h06);
   endtask
   // Four-line mode entry, refused single-line read, exit; then busy refusal
   task automatic t_quad();
      h.open_frame(1'b0);
      h.send(8'h35, 1, 8);
      h.close_frame();
      chk("quad_on", quad_mode_o, 1);
      h.open_frame(1'b0);
      h.send(8'h03, 4, 2);
      h.send(8'h00, 4, 2);
      chk("quad_rd03", active_o, 0);
      h.close_frame();
      h.open_frame(1'b0);
      h.send(8'hF5, 4, 2);
      h.close_frame();
      chk("quad_off", quad_mode_o, 0);
      busy_i <= 1'b1;
      h.open_frame(1'b0);
      h.send(8'h03, 1, 8);
      h.send(8'h00, 1, 8);
      chk("busy_rd", active_o, 0);
      h.close_frame();
      busy_i <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      err_count = 0;
      total_checks = 0;
      exec_cnt = 0;
      reset_i = 1'b1;
      busy_i = 1'b0;
      dummy_cfg = 2'h0;
      lock_wr_i = 1'b0;
      lock_val_i = 1'b0;
      lock_addr_i = 24'h00_0000;
      repeat (16) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      t_read();
      t_fast();
      t_cmd();
      t_quad();
      stop_test();
   end
   // Whole run needs about 1500 clocks
   initial begin
      repeat (40000) @(posedge clk_sys_i);
      err_count++;
      stop_test();
   end
endmodule
